// ---- cdr_record_builder.sv ----
`timescale 1ns/10ps
`include "cdr_map.svh"

module cdr_record_builder
   import cdr_pkg::*;
#(
   parameter int NUM_INPUTS   = 16,  // digital inputs with edge events
   parameter int NUM_COUNTERS = 3,   // counters
   parameter int EV_PER_CNT   = 4    // events per counter
)
(
   input  wire logic                                  i_ref_clk,       // module clock
   input  wire logic                                  i_resetn,        // async reset
   input  wire logic [NUM_INPUTS-1:0]                 i_in_evt,        // input edges
   input  wire logic [NUM_INPUTS-1:0]                 i_in_done,       // input service done
   input  wire logic [NUM_COUNTERS*EV_PER_CNT-1:0]    i_cnt_evt,       // counter events
   input  wire logic [NUM_COUNTERS*EV_PER_CNT-1:0]    i_cnt_done,      // counter service done
   input  wire logic                                  i_tech_selected, // technology in use
   input  wire logic                                  i_diag_proc_cfg, // combined option set
   input  wire logic                                  i_diag_irq_en,   // diagnosis release
   input  wire logic                                  i_module_fail,   // module failure
   input  wire logic                                  i_external_err,  // external error
   input  wire logic                                  i_class_digital, // 1 digital, 0 analog
   input  wire logic                                  i_more_types,    // more channel types
   input  wire logic [6:0]                            i_group_err,     // group errors
   input  wire logic                                  i_rd_req,        // read request
   input  wire logic                                  i_rd_set,        // 0 set 0, 1 set 1
   input  wire logic [3:0]                            i_rd_index,      // byte index
   output logic      [7:0]                            o_rd_data,       // read byte
   output logic                                       o_rd_valid,      // read strobe
   output logic      [NUM_INPUTS-1:0]                 o_in_irq,        // input process irq
   output logic      [NUM_COUNTERS*EV_PER_CNT-1:0]    o_cnt_irq,       // counter process irq
   output logic                                       o_diag_incoming, // incoming pulse
   output logic                                       o_diag_outgoing, // outgoing pulse
   output logic                                       o_diag_active,   // any diagnosis open
   output cdr_pkg::cdr_phase_t                        o_msg_phase      // form of set 0
);

   localparam int NUM_CNT_EV = NUM_COUNTERS * EV_PER_CNT;  // counter event total

   cdr_main_st_t            st_reg;      // registered state
   cdr_main_st_t            st_next;     // next state

   logic                    diag_allow;  // diagnosis permitted
   logic [NUM_INPUTS-1:0]   in_lost;     // lost flags inputs
   logic [NUM_INPUTS-1:0]   in_set;      // opened pulses inputs
   logic [NUM_INPUTS-1:0]   in_clr;      // closed pulses inputs
   logic [NUM_CNT_EV-1:0]   cnt_lost;    // lost flags counters
   logic [NUM_CNT_EV-1:0]   cnt_set;     // opened pulses counters
   logic [NUM_CNT_EV-1:0]   cnt_clr;     // closed pulses counters
   logic                    any_lost;    // any lost flag
   logic                    any_set;     // any opened pulse
   logic                    any_clr;     // any closed pulse

   logic [7:0]              b_fault;     // byte 0
   logic [7:0]              b_class;     // byte 1
   logic [7:0]              b_pad_high;  // byte 3
   logic [7:0]              b_chtype;    // byte 4
   logic [7:0]              b_group;     // byte 7
   logic [7:0]              b_in [4];    // bytes 8 to 11
   logic [7:0]              b_cnt [3];   // bytes 12 to 14
   logic [7:0]              rec_byte;    // selected byte

   // spreads four flags onto the even bits of a byte
   function automatic logic [7:0] spread4(input logic [3:0] f);
      logic [7:0] b;
      b = 8'h00;
      b[0] = f[0];
      b[2] = f[1];
      b[4] = f[2];
      b[6] = f[3];
      return b;
   endfunction : spread4

   // gate for diagnostic interrupts
   always_comb
   begin
      diag_allow = i_tech_selected && i_diag_proc_cfg && i_diag_irq_en;
   end

   // one tracker per input event
   for (genvar gi = 0; gi < NUM_INPUTS; gi++)
   begin : g_in
      cdr_event_track u_trk
      (
         .i_ref_clk (i_ref_clk),
         .i_resetn  (i_resetn),
         .i_evt     (i_in_evt[gi]),
         .i_done    (i_in_done[gi]),
         .i_allow   (diag_allow),
         .o_fwd     (o_in_irq[gi]),
         .o_lost    (in_lost[gi]),
         .o_set     (in_set[gi]),
         .o_clr     (in_clr[gi])
      );
   end

   // one tracker per counter event
   for (genvar gc = 0; gc < NUM_CNT_EV; gc++)
   begin : g_cnt
      cdr_event_track u_trk
      (
         .i_ref_clk (i_ref_clk),
         .i_resetn  (i_resetn),
         .i_evt     (i_cnt_evt[gc]),
         .i_done    (i_cnt_done[gc]),
         .i_allow   (diag_allow),
         .o_fwd     (o_cnt_irq[gc]),
         .o_lost    (cnt_lost[gc]),
         .o_set     (cnt_set[gc]),
         .o_clr     (cnt_clr[gc])
      );
   end

   // summaries over all trackers
   always_comb
   begin
      any_lost = (|in_lost) || (|cnt_lost);
      any_set  = (|in_set) || (|cnt_set);
      any_clr  = (|in_clr) || (|cnt_clr);
   end

   // bytes of record set 0, same for every function
   always_comb
   begin
      // byte 0: error summary, fixed bits zero
      b_fault                   = `CDR_ZERO_BYTE;
      b_fault[`CDR_B0_FAIL_BIT] = i_module_fail;
      b_fault[`CDR_B0_EXT_BIT]  = i_external_err;
      b_fault[`CDR_B0_CHAN_BIT] = any_lost || (|i_group_err);
      // byte 1: module class and channel info
      b_class      = `CDR_ZERO_BYTE;
      b_class[3:0] = i_class_digital ? `CDR_CLASS_DIGITAL : `CDR_CLASS_ANALOG;
      b_class[`CDR_B1_CHINFO_BIT] = 1'b1;
      // byte 3: lost flag only in the incoming form
      b_pad_high = `CDR_ZERO_BYTE;
      if (st_reg.phase == ph_incoming)
      begin
         b_pad_high[`CDR_B3_LOST_BIT] = any_lost;
      end
   end

   // module specific bytes of record set 1
   always_comb
   begin
      // byte 4: channel type and more-types flag
      b_chtype                   = {1'b0, `CDR_CHTYPE_DIN};
      b_chtype[`CDR_B4_MORE_BIT] = i_more_types;
      // byte 7: group errors, top bit reserved
      b_group = {1'b0, i_group_err};
      // bytes 8 to 11: four inputs per byte, ascending
      for (int k = 0; k < 4; k++)
      begin
         b_in[k] = spread4(in_lost[k*4 +: 4]);
      end
      // bytes 12 to 14: closed, opened, over/underflow, compare
      for (int c = 0; c < 3; c++)
      begin
         b_cnt[c] = spread4(cnt_lost[c*EV_PER_CNT +: 4]);
      end
   end

   // selects the byte that a read asks for
   always_comb
   begin
      rec_byte = `CDR_ZERO_BYTE;
      unique case (i_rd_index)
         `CDR_IDX_FAULT:    rec_byte = b_fault;
         `CDR_IDX_CLASS:    rec_byte = b_class;
         `CDR_IDX_PAD_LOW:  rec_byte = `CDR_ZERO_BYTE;
         `CDR_IDX_PAD_HIGH: rec_byte = b_pad_high;
         `CDR_IDX_CHTYPE:   rec_byte = b_chtype;
         `CDR_IDX_BITS_CH:  rec_byte = `CDR_BITS_PER_CH;
         `CDR_IDX_CH_COUNT: rec_byte = `CDR_NUM_CHANNELS;
         `CDR_IDX_GROUP:    rec_byte = b_group;
         `CDR_IDX_IN_A:     rec_byte = b_in[0];
         `CDR_IDX_IN_B:     rec_byte = b_in[1];
         `CDR_IDX_IN_C:     rec_byte = b_in[2];
         `CDR_IDX_IN_D:     rec_byte = b_in[3];
         `CDR_IDX_CNT0:     rec_byte = b_cnt[0];
         `CDR_IDX_CNT1:     rec_byte = b_cnt[1];
         `CDR_IDX_CNT2:     rec_byte = b_cnt[2];
         `CDR_IDX_RSV_TAIL: rec_byte = `CDR_ZERO_BYTE;
      endcase
      // set 0 holds only its first four bytes
      if (!i_rd_set && (i_rd_index > `CDR_IDX_PAD_HIGH))
      begin
         rec_byte = `CDR_ZERO_BYTE;
      end
   end

   // next state: read answer and message sequencing
   always_comb
   begin
      st_next          = st_reg;
      st_next.rd_valid = i_rd_req;
      st_next.msg_in   = 1'b0;
      st_next.msg_out  = 1'b0;
      // read answer registered one cycle later
      if (i_rd_req)
      begin
         st_next.rd_data = rec_byte;
      end
      // outgoing message only while release still set
      if (any_clr && i_diag_irq_en)
      begin
         st_next.msg_out = 1'b1;
         st_next.phase   = ph_outgoing;
      end
      // a new incoming diagnosis wins the form of set 0
      if (any_set)
      begin
         st_next.msg_in = 1'b1;
         st_next.phase  = ph_incoming;
      end
   end

   // state register
   always_ff @(posedge i_ref_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         st_reg.rd_data  <= 8'h00;
         st_reg.rd_valid <= 1'b0;
         st_reg.phase    <= ph_quiet;
         st_reg.msg_in   <= 1'b0;
         st_reg.msg_out  <= 1'b0;
      end
      else
      begin
         st_reg <= st_next;
      end
   end

   // outputs from registers
   assign o_rd_data       = st_reg.rd_data;
   assign o_rd_valid      = st_reg.rd_valid;
   assign o_diag_incoming = st_reg.msg_in;
   assign o_diag_outgoing = st_reg.msg_out;
   assign o_msg_phase     = st_reg.phase;
   assign o_diag_active   = any_lost;

endmodule : cdr_record_builder

// ---- cdr_map.svh ----
`ifndef CDR_MAP_SVH
`define CDR_MAP_SVH

// byte indices within a diagnostic record
`define CDR_IDX_FAULT      4'h0
`define CDR_IDX_CLASS      4'h1
`define CDR_IDX_PAD_LOW    4'h2
`define CDR_IDX_PAD_HIGH   4'h3
`define CDR_IDX_CHTYPE     4'h4
`define CDR_IDX_BITS_CH    4'h5
`define CDR_IDX_CH_COUNT   4'h6
`define CDR_IDX_GROUP      4'h7
`define CDR_IDX_IN_A       4'h8
`define CDR_IDX_IN_B       4'h9
`define CDR_IDX_IN_C       4'ha
`define CDR_IDX_IN_D       4'hb
`define CDR_IDX_CNT0       4'hc
`define CDR_IDX_CNT1       4'hd
`define CDR_IDX_CNT2       4'he
`define CDR_IDX_RSV_TAIL   4'hf

// field positions
`define CDR_B0_FAIL_BIT    0
`define CDR_B0_EXT_BIT     2
`define CDR_B0_CHAN_BIT    3
`define CDR_B1_CHINFO_BIT  4
`define CDR_B3_LOST_BIT    6
`define CDR_B4_MORE_BIT    7

// fixed codes and reset values
`define CDR_CLASS_ANALOG   4'h5
`define CDR_CLASS_DIGITAL  4'hf
`define CDR_CHTYPE_DIN     7'h70
`define CDR_BITS_PER_CH    8'h08
`define CDR_NUM_CHANNELS   8'h08
`define CDR_ZERO_BYTE      8'h00

`endif

// ---- cdr_pkg.sv ----
package cdr_pkg;

   // which message form record set 0 currently carries
   typedef enum logic [1:0]
   {
      ph_quiet,
      ph_incoming,
      ph_outgoing
   } cdr_phase_t;

   // state of one event tracker
   typedef struct packed
   {
      logic busy;   // process interrupt being serviced
      logic lost;   // recurrence seen, diagnosis open
      logic fwd;    // process interrupt pulse
      logic set_p;  // diagnosis opened pulse
      logic clr_p;  // diagnosis closed pulse
   } cdr_trk_st_t;

   // state of the record builder
   typedef struct packed
   {
      logic [7:0] rd_data;  // read answer byte
      logic       rd_valid; // read answer strobe
      cdr_phase_t phase;    // current message form
      logic       msg_in;   // incoming message pulse
      logic       msg_out;  // outgoing message pulse
   } cdr_main_st_t;

endpackage : cdr_pkg

// ---- cdr_event_track.sv ----
`timescale 1ns/10ps

module cdr_event_track
   import cdr_pkg::*;
(
   input  wire logic i_ref_clk,  // module clock
   input  wire logic i_resetn,   // async reset, active low
   input  wire logic i_evt,      // event occurred, one cycle
   input  wire logic i_done,     // servicing of this event finished
   input  wire logic i_allow,    // diagnostic interrupts permitted
   output logic      o_fwd,      // process interrupt pulse
   output logic      o_lost,     // lost flag level
   output logic      o_set,      // diagnosis opened pulse
   output logic      o_clr       // diagnosis closed pulse
);

   cdr_trk_st_t st_reg;   // registered state
   cdr_trk_st_t st_next;  // next state

   // next state of one event
   always_comb
   begin
      st_next       = st_reg;
      st_next.fwd   = 1'b0;
      st_next.set_p = 1'b0;
      st_next.clr_p = 1'b0;
      if (st_reg.lost)
      begin
         // new events are dropped while diagnosis open
         if (i_done)
         begin
            st_next.lost  = 1'b0;
            st_next.busy  = 1'b0;
            st_next.clr_p = 1'b1;
         end
      end
      else if (st_reg.busy)
      begin
         // recurrence during servicing
         if (i_evt && !i_done && i_allow)
         begin
            st_next.lost  = 1'b1;
            st_next.set_p = 1'b1;
         end
         else if (i_done)
         begin
            // event on the done edge starts a new service
            st_next.busy = i_evt;
            st_next.fwd  = i_evt;
         end
      end
      else if (i_evt)
      begin
         // first occurrence goes out as process interrupt
         st_next.busy = 1'b1;
         st_next.fwd  = 1'b1;
      end
   end

   // state register
   always_ff @(posedge i_ref_clk or negedge i_resetn)
   begin
      if (!i_resetn)
         st_reg <= '0;
      else
         st_reg <= st_next;
   end

   assign o_fwd  = st_reg.fwd;
   assign o_lost = st_reg.lost;
   assign o_set  = st_reg.set_p;
   assign o_clr  = st_reg.clr_p;

endmodule : cdr_event_track

// ---- cdr_record_builder_properties.sv ----
`timescale 1ns/10ps

module cdr_record_builder_checker
   import cdr_pkg::*;
#(
   parameter int NUM_INPUTS   = 16, // inputs with edge events
   parameter int NUM_COUNTERS = 3,  // counters
   parameter int EV_PER_CNT   = 4   // events per counter
)
(
   input wire logic                               i_ref_clk,
   input wire logic                               i_resetn,
   input wire logic [NUM_INPUTS-1:0]              i_in_evt,
   input wire logic [NUM_INPUTS-1:0]              i_in_done,
   input wire logic [NUM_COUNTERS*EV_PER_CNT-1:0] i_cnt_evt,
   input wire logic [NUM_COUNTERS*EV_PER_CNT-1:0] i_cnt_done,
   input wire logic                               i_tech_selected,
   input wire logic                               i_diag_proc_cfg,
   input wire logic                               i_diag_irq_en,
   input wire logic                               i_module_fail,
   input wire logic                               i_external_err,
   input wire logic                               i_class_digital,
   input wire logic                               i_more_types,
   input wire logic [6:0]                         i_group_err,
   input wire logic                               i_rd_req,
   input wire logic                               i_rd_set,
   input wire logic [3:0]                         i_rd_index,
   input wire logic [7:0]                         o_rd_data,
   input wire logic                               o_rd_valid,
   input wire logic [NUM_INPUTS-1:0]              o_in_irq,
   input wire logic [NUM_COUNTERS*EV_PER_CNT-1:0] o_cnt_irq,
   input wire logic                               o_diag_incoming,
   input wire logic                               o_diag_outgoing,
   input wire logic                               o_diag_active,
   input wire cdr_pkg::cdr_phase_t                o_msg_phase
);
   // one clock domain, reset disables all checks
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (!i_resetn);

   // read answer strobe exactly one cycle later
   read_answer_a : assert property (i_rd_req |=> o_rd_valid)
      else $error("read strobe missing");
   read_data_hold_a : assert property (!i_rd_req |=> !o_rd_valid && $stable(o_rd_data))
      else $error("read data moved without a read");
   // byte 0 fixed bits and external error bit
   fault_byte_a : assert property (i_rd_req && i_rd_index == 4'h0 |=>
      o_rd_data[7:4] == 4'h0 && !o_rd_data[1] && o_rd_data[2] == $past(i_external_err))
      else $error("fault byte wrong");
   // byte 1 class code and channel info
   class_byte_a : assert property (i_rd_req && i_rd_index == 4'h1 |=>
      o_rd_data == {4'h1, $past(i_class_digital) ? 4'hf : 4'h5})
      else $error("class byte wrong");
   // byte 2 is always zero, set 0 beyond byte 3 reads zero
   pad_zero_a : assert property (i_rd_req && (i_rd_index == 4'h2 ||
      (!i_rd_set && i_rd_index > 4'h3)) |=> o_rd_data == 8'h00)
      else $error("pad byte not zero");
   // channel type with more-types bit
   chan_type_a : assert property (i_rd_req && i_rd_set && i_rd_index == 4'h4 |=>
      o_rd_data == {$past(i_more_types), 7'h70})
      else $error("channel type wrong");
   // bits per channel and channel count
   fixed_counts_a : assert property (i_rd_req && i_rd_set &&
      (i_rd_index == 4'h5 || i_rd_index == 4'h6) |=> o_rd_data == 8'h08)
      else $error("fixed count byte wrong");
   // no diagnosis unless all three enables held; tracker flag then message register
   diag_gate_a : assert property (!(i_tech_selected && i_diag_proc_cfg && i_diag_irq_en)
      |-> ##2 !o_diag_incoming)
      else $error("diagnosis opened while not allowed");
   // outgoing message only while release active
   outgoing_en_a : assert property (o_diag_outgoing |-> $past(i_diag_irq_en))
      else $error("outgoing message without release");
   // incoming shows lost flag and incoming phase
   incoming_state_a : assert property (o_diag_incoming |->
      o_diag_active && o_msg_phase == ph_incoming)
      else $error("incoming state wrong");

   // main scenarios
   cover property (o_diag_incoming);
   cover property (o_diag_outgoing);
   cover property (i_rd_req && i_rd_set && i_rd_index == 4'hc);
endmodule : cdr_record_builder_checker

bind cdr_record_builder cdr_record_builder_checker #(
   .NUM_INPUTS(NUM_INPUTS), .NUM_COUNTERS(NUM_COUNTERS), .EV_PER_CNT(EV_PER_CNT)
) u_chk (
   .i_ref_clk(i_ref_clk), .i_resetn(i_resetn), .i_in_evt(i_in_evt),
   .i_in_done(i_in_done), .i_cnt_evt(i_cnt_evt), .i_cnt_done(i_cnt_done),
   .i_tech_selected(i_tech_selected), .i_diag_proc_cfg(i_diag_proc_cfg),
   .i_diag_irq_en(i_diag_irq_en), .i_module_fail(i_module_fail),
   .i_external_err(i_external_err), .i_class_digital(i_class_digital),
   .i_more_types(i_more_types), .i_group_err(i_group_err), .i_rd_req(i_rd_req),
   .i_rd_set(i_rd_set), .i_rd_index(i_rd_index), .o_rd_data(o_rd_data),
   .o_rd_valid(o_rd_valid), .o_in_irq(o_in_irq), .o_cnt_irq(o_cnt_irq),
   .o_diag_incoming(o_diag_incoming), .o_diag_outgoing(o_diag_outgoing),
   .o_diag_active(o_diag_active), .o_msg_phase(o_msg_phase)
);

// ---- tb_cdr_record_builder.sv ----
`timescale 1ns/10ps

module tb_cdr_record_builder;
   import cdr_pkg::*;
   logic        i_ref_clk = 1'b0;                    // module clock
   logic        i_resetn = 1'b0;                     // reset, active low
   logic [15:0] i_in_evt = '0, i_in_done = '0;       // input events
   logic [11:0] i_cnt_evt = '0, i_cnt_done = '0;     // counter events
   logic        i_tech_selected = 1'b1, i_diag_proc_cfg = 1'b1, i_diag_irq_en = 1'b1;
   logic        i_module_fail = 1'b0, i_external_err = 1'b0;
   logic        i_class_digital = 1'b0, i_more_types = 1'b0;
   logic [6:0]  i_group_err = '0;                    // group errors
   logic        i_rd_req = 1'b0, i_rd_set = 1'b0;    // read request
   logic [3:0]  i_rd_index = '0;                     // byte index
   logic [7:0]  o_rd_data;                           // read byte
   logic        o_rd_valid, o_diag_incoming, o_diag_outgoing, o_diag_active;
   logic [15:0] o_in_irq;                            // input process irq
   logic [11:0] o_cnt_irq;                           // counter process irq
   cdr_phase_t  o_msg_phase;                         // message form
   logic [15:0] lost_in = '0;                        // expected lost inputs
   logic [11:0] lost_cnt = '0;                       // expected lost counter events
   cdr_phase_t  exp_phase = ph_quiet;                // expected form
   logic [31:0] seed = 32'h00013491;                 // random state
   int          miscompares = 0;                     // mismatch count
   int          n_compared = 0;                      // comparison count

   // 200 MHz clock
   always #2.5 i_ref_clk = ~i_ref_clk;

   cdr_record_builder uut (
      .i_ref_clk(i_ref_clk), .i_resetn(i_resetn), .i_in_evt(i_in_evt),
      .i_in_done(i_in_done), .i_cnt_evt(i_cnt_evt), .i_cnt_done(i_cnt_done),
      .i_tech_selected(i_tech_selected), .i_diag_proc_cfg(i_diag_proc_cfg),
      .i_diag_irq_en(i_diag_irq_en), .i_module_fail(i_module_fail),
      .i_external_err(i_external_err), .i_class_digital(i_class_digital),
      .i_more_types(i_more_types), .i_group_err(i_group_err), .i_rd_req(i_rd_req),
      .i_rd_set(i_rd_set), .i_rd_index(i_rd_index), .o_rd_data(o_rd_data),
      .o_rd_valid(o_rd_valid), .o_in_irq(o_in_irq), .o_cnt_irq(o_cnt_irq),
      .o_diag_incoming(o_diag_incoming), .o_diag_outgoing(o_diag_outgoing),
      .o_diag_active(o_diag_active), .o_msg_phase(o_msg_phase));

   // next random state
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr

   // expected record byte from live inputs and lost model
   function automatic logic [7:0] exp_byte(input logic s, input logic [3:0] ix);
      logic [7:0] b;
      logic       any;
      any = |{lost_in, lost_cnt};
      b = 8'h00;
      case (ix)
         4'h0: b = {4'h0, any | (|i_group_err), i_external_err, 1'b0, i_module_fail};
         4'h1: b = {4'h1, i_class_digital ? 4'hf : 4'h5};
         4'h3: b = {1'b0, any && exp_phase == ph_incoming, 6'h00};
         4'h4: b = {i_more_types, 7'h70};
         4'h5, 4'h6: b = 8'h08;
         4'h7: b = {1'b0, i_group_err};
         4'h8, 4'h9, 4'ha, 4'hb: for (int k = 0; k < 4; k++) b[2*k] = lost_in[4*(ix-8)+k];
         4'hc, 4'hd, 4'he: for (int k = 0; k < 4; k++) b[2*k] = lost_cnt[4*(ix-12)+k];
         default: b = 8'h00;
      endcase
      if (!s && ix > 4'h3)
      begin
         b = 8'h00;
      end
      return b;
   endfunction : exp_byte

   // compare and report
   task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
         miscompares++;
      end
   endtask : chk

   // drive event lines for one cycle, outputs of that edge settled after
   task automatic step(input logic [15:0] ie, id, input logic [11:0] ce, cd);
      i_in_evt = ie;
      i_in_done = id;
      i_cnt_evt = ce;
      i_cnt_done = cd;
      @(negedge i_ref_clk);
   endtask : step

   // one register read, checked one cycle later
   task automatic rd(input logic s, input logic [3:0] ix);
      logic [7:0] e;
      e = exp_byte(s, ix);
      i_rd_req = 1'b1;
      i_rd_set = s;
      i_rd_index = ix;
      @(negedge i_ref_clk);
      i_rd_req = 1'b0;
      chk("rd_valid", 8'(o_rd_valid), 8'h01);
      chk("rd_data", o_rd_data, e);
      @(negedge i_ref_clk);
   endtask : rd

   // event twice in a row while servicing opens a diagnosis
   task automatic lose2(input logic c, input int n);
      logic [15:0] ie;
      logic [11:0] ce;
      ie = c ? 16'h0 : 16'(1) << n;
      ce = c ? 12'(1) << n : 12'h0;
      step(ie, 16'h0, ce, 12'h0);
      chk("irq", 8'(|{o_in_irq & ie, o_cnt_irq & ce}), 8'h01);
      step(ie, 16'h0, ce, 12'h0);
      if (c) lost_cnt[n] = 1'b1; else lost_in[n] = 1'b1;
      exp_phase = ph_incoming;
      chk("active", 8'(o_diag_active), 8'h01);
      // message and form are registered one cycle after the tracker flag
      step('0, '0, '0, '0);
      chk("incoming", 8'(o_diag_incoming), 8'h01);
      chk("phase", 8'(o_msg_phase), 8'(ph_incoming));
   endtask : lose2

   // verdict and end of run
   task automatic end_of_test();
      if (miscompares == 0 && n_compared > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : end_of_test

   // hang guard
   initial
   begin
      repeat (20000) @(posedge i_ref_clk);
      miscompares++;
      end_of_test();
   end

   // main sequence
   initial
   begin
      repeat (5) @(negedge i_ref_clk);
      i_resetn = 1'b1;
      // every byte of both sets, random live inputs
      for (int i = 0; i < 64; i++)
      begin
         seed = lfsr(seed);
         {i_module_fail, i_external_err, i_class_digital, i_more_types, i_group_err} = seed[10:0];
         rd(i[4], i[3:0]);
      end
      i_group_err = '0;
      // lost input, visible in set 0 and set 1
      lose2(1'b0, 5);
      rd(1'b0, 4'h3);
      rd(1'b1, 4'h9);
      rd(1'b0, 4'h0);
      // lost counter compare event, later events discarded
      lose2(1'b1, 11);
      step('0, '0, 12'h800, '0);
      chk("discard", 8'(o_cnt_irq[11]), 8'h00);
      step('0, '0, '0, '0);
      rd(1'b1, 4'he);
      // clearing with release active gives outgoing message
      step('0, 16'h0020, '0, '0);
      lost_in = '0;
      exp_phase = ph_outgoing;
      step('0, '0, '0, '0);
      chk("outgoing", 8'(o_diag_outgoing), 8'h01);
      chk("phase_out", 8'(o_msg_phase), 8'(ph_outgoing));
      rd(1'b0, 4'h3);
      // clearing without release stays silent
      i_diag_irq_en = 1'b0;
      step('0, '0, '0, 12'h800);
      lost_cnt = '0;
      step('0, '0, '0, '0);
      chk("no_outgoing", 8'(o_diag_outgoing), 8'h00);
      chk("inactive", 8'(o_diag_active), 8'h00);
      // no technology selected: recurrence dropped, no diagnosis
      i_diag_irq_en = 1'b1;
      i_tech_selected = 1'b0;
      step(16'h0001, '0, '0, '0);
      step(16'h0001, '0, '0, '0);
      chk("dropped", 8'(o_in_irq[0]), 8'h00);
      step('0, 16'h0001, '0, '0);
      chk("no_incoming", 8'(o_diag_incoming), 8'h00);
      step('0, '0, '0, '0);
      rd(1'b1, 4'h8);
      end_of_test();
   end
endmodule : tb_cdr_record_builder
